// File: hdl/rlsb_pkg.sv
/*
 * rlsb_pkg: offsets, field positions, reset values, timing and carrier
 * types for the receive latched status bank.
 * Assumes a single 20 MHz system clock and an 8-bit host register port.
 */
package rlsb_pkg;

	// register offsets on the 8-bit host port
	localparam logic [7:0] OFF_MSG_STATUS = 8'h94;
	localparam logic [7:0] OFF_LINK_STATUS = 8'h96;
	localparam logic [7:0] OFF_SIG_CHG_1_8 = 8'h98;
	localparam logic [7:0] OFF_SIG_CHG_9_16 = 8'h99;
	localparam logic [7:0] OFF_SIG_CHG_17_24 = 8'h9A;
	localparam logic [7:0] OFF_SIG_CHG_25_32 = 8'h9B;
	localparam logic [7:0] OFF_SPARE_CODE_HI = 8'h9C;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// message status field positions
	localparam int MSG_OVERRUN_BIT = 5;
	localparam int MSG_OPEN_BYTE_BIT = 4;
	localparam int MSG_PKT_END_BIT = 3;
	localparam int MSG_PKT_START_BIT = 2;
	localparam int MSG_HWM_BIT = 1;
	localparam int MSG_NOT_EMPTY_BIT = 0;

	// link status field positions, 1.544 mode
	localparam int LNK_RAI_CI_BIT = 5;
	localparam int LNK_AIS_CI_BIT = 4;
	localparam int LNK_SLC_ALIGN_BIT = 3;
	localparam int LNK_DL_FULL_BIT = 2;
	localparam int LNK_BOC_CLEAR_BIT = 1;
	localparam int LNK_BOC_DETECT_BIT = 0;
	// link status field positions, 2.048 mode
	localparam int LNK_SPARE6_BIT = 1;
	localparam int LNK_SPARE_CHG_BIT = 0;

	// signalling change banks
	localparam int SIG_BANKS = 4;
	localparam int SIG_BANK_E1_ONLY = 3;
	localparam int CHANNELS = 32;
	localparam int SPARE_BITS = 5;

	// spare-code pattern length handling
	localparam int CODE_BYTE_BITS = 8;
	localparam logic [3:0] CODE_LEN_HI_FULL = 4'h8;

	// free-running multiframe period in the 2.048 mode
	localparam int CLK_KHZ = 20000;
	localparam int MF_E1_PERIOD_US = 2000;
	localparam int MF_E1_CYCLES = (MF_E1_PERIOD_US * CLK_KHZ) / 1000;

	// host access carrier
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rlsb_host_req_s;

	// message receiver event carrier
	typedef struct packed {
		logic overrun;
		logic opening_byte_at_head;
		logic end_valid;
		logic end_crc_error;
		logic end_abort;
		logic packet_start;
		logic above_high_watermark;
		logic buffer_not_empty;
	} rlsb_msg_evt_s;

	// framer line-link event carrier
	typedef struct packed {
		logic remote_alarm_ci_pattern;
		logic remote_alarm_present;
		logic alarm_indication_ci_pattern;
		logic alarm_indication_present;
		logic subscriber_carrier_alignment;
		logic slc_data_ready;
		logic data_link_full_event;
		logic bit_message_detect;
		logic bit_message_clear;
		logic spare6_codeword_detect;
		logic spare_sample;
		logic [SPARE_BITS-1:0] spare_bits;
	} rlsb_link_evt_s;

endpackage

// File: hdl/rlsb_status_bank.sv
/*
 * rlsb_status_bank: receive latched status of one framer channel.
 * Latches message-receiver, line-link and signalling change events for
 * host software, clear on read, and holds the first spare-code register.
 * Assumes all event inputs come from logic on sys_clk; the host port is
 * a synchronous one-cycle read or write strobe with an 8-bit address.
 *
 * Surroundings expected:
 * - the framer, message receiver and signalling extractor hand over
 *   one-cycle event pulses, or levels where a rising edge is the event;
 * - the mask and summary registers that turn these latches into an
 *   interrupt line live outside, except the signalling summary pulse;
 * - the spare-code detector itself lives outside and consumes the
 *   care mask, the masked pattern and the restart pulse;
 * - the second spare-code byte lives outside; for lengths up to eight
 *   the detector must ignore it entirely;
 * - reads clear status at the same edge that loads host_rdata,
 *   so software must not issue a speculative read of a status register;
 * - every latch gives priority to a new event over a clearing read, so
 *   an event arriving during the read is seen on the next read.
 */
//
// Behaviour
// - 1.544: multiframe event per superframe, 1.5/3ms
// - 2.048: event every 2.0ms, free-running without CAS
// - every message status bit latched, can interrupt
// - overrun flag when buffer full stops packet
// - opening-byte flag when head byte starts message
// - packet-end on good end or fault; read clears
// - packet-start on opening byte; read clears
// - high-watermark flag on rising crossing
// - not-empty flag on empty to occupied edge
// - remote-alarm CI flag: extended superframe, alarm present
// - alarm-indication CI flag only while AIS present
// - alignment flag when pattern found, data ready
// - data link full flag each filled byte
// - bit message detect and clear flags
// - 2.048: spare-bit-6 codeword flag
// - 2.048: enabled spare bit change flag
// - per-channel signalling change bits, fourth bank 2.048
// - summary only for enabled channels, masked interrupt
// - signalling change bit held until read
// - 2.048 CAS: bank LSBs carry alignment slots
// - spare-code write restarts detector integration
// - top code bit first; short lengths ignore bits
// - beyond-length bits ignored; second byte ignored
`timescale 1ns/100ps
`default_nettype none

module rlsb_status_bank #(
	parameter int MF_CYCLES = rlsb_pkg::MF_E1_CYCLES,
	parameter int MF_CNT_W = 16
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire rlsb_pkg::rlsb_host_req_s host_req,
	output logic [7:0] host_rdata,
	input wire logic mode_e1,
	input wire logic esf_mode,
	input wire logic cas_enable,
	input wire logic superframe_boundary,
	input wire logic cas_mf_boundary,
	input wire rlsb_pkg::rlsb_msg_evt_s msg_evt,
	input wire rlsb_pkg::rlsb_link_evt_s link_evt,
	input wire logic [rlsb_pkg::SPARE_BITS-1:0] spare_bit_select_mask,
	input wire logic [rlsb_pkg::CHANNELS-1:0] sig_state_change,
	input wire logic [rlsb_pkg::CHANNELS-1:0] signalling_change_enable,
	input wire logic event_interrupt_mask,
	input wire logic [3:0] spare_code_length,
	output logic multiframe_event,
	output logic signalling_change_summary,
	output logic interrupt_out_n,
	output logic [7:0] spare_code_care,
	output logic [7:0] spare_code_pattern,
	output logic spare_code_restart
);

	// last count of the free-running base; MF_CYCLES must fit MF_CNT_W
	localparam logic [MF_CNT_W-1:0] MF_LAST = MF_CNT_W'(MF_CYCLES - 1);


	// host strobes decoded per register
	logic rd_msg, rd_link, wr_code;
	logic [rlsb_pkg::SIG_BANKS-1:0] rd_sig;
	assign rd_msg = host_req.rd && (host_req.addr == rlsb_pkg::OFF_MSG_STATUS);
	assign rd_link = host_req.rd && (host_req.addr == rlsb_pkg::OFF_LINK_STATUS);
	assign wr_code = host_req.wr && (host_req.addr == rlsb_pkg::OFF_SPARE_CODE_HI);
	assign rd_sig[0] = host_req.rd && (host_req.addr == rlsb_pkg::OFF_SIG_CHG_1_8);
	assign rd_sig[1] = host_req.rd && (host_req.addr == rlsb_pkg::OFF_SIG_CHG_9_16);
	assign rd_sig[2] = host_req.rd && (host_req.addr == rlsb_pkg::OFF_SIG_CHG_17_24);
	assign rd_sig[3] = host_req.rd && (host_req.addr == rlsb_pkg::OFF_SIG_CHG_25_32);

	// ---------------------------------------------------------------
	// multiframe event generation
	logic [MF_CNT_W-1:0] mf_cnt_r;
	logic mf_free_tick;
	assign mf_free_tick = (mf_cnt_r == MF_LAST);


	// free-running 2.0 ms base, used when CAS is off; it keeps counting
	// in every mode so the boundary stays arbitrary but regular
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mf_cnt_r <= '0;
		end else if (mf_free_tick) begin
			mf_cnt_r <= '0;
		end else begin
			mf_cnt_r <= mf_cnt_r + 1'b1;
		end
	end


	// one pulse per multiframe boundary for the selected line mode;
	// the framer boundaries pass through with one cycle of delay
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			multiframe_event <= 1'b0;
		end else if (!mode_e1) begin
			multiframe_event <= superframe_boundary;
		end else if (cas_enable) begin
			multiframe_event <= cas_mf_boundary;
		end else begin
			multiframe_event <= mf_free_tick;
		end
	end

	// ---------------------------------------------------------------
	// message receiver status
	logic hwm_d_r, ne_d_r;
	logic [7:0] msg_set, msg_r;


	// previous levels for rising-edge detection; both idle low after
	// reset, so a buffer already occupied at release gives one event
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hwm_d_r <= 1'b0;
			ne_d_r <= 1'b0;
		end else begin
			hwm_d_r <= msg_evt.above_high_watermark;
			ne_d_r <= msg_evt.buffer_not_empty;
		end
	end


	// event sources of the message status byte; an overrun also ends
	// the packet, so it sets the packet-end bit in the same cycle
	always_comb begin
		msg_set = '0;
		msg_set[rlsb_pkg::MSG_OVERRUN_BIT] = msg_evt.overrun;
		msg_set[rlsb_pkg::MSG_OPEN_BYTE_BIT] = msg_evt.opening_byte_at_head;
		msg_set[rlsb_pkg::MSG_PKT_END_BIT] = msg_evt.end_valid | msg_evt.end_crc_error
			| msg_evt.overrun | msg_evt.end_abort;
		msg_set[rlsb_pkg::MSG_PKT_START_BIT] = msg_evt.packet_start;
		msg_set[rlsb_pkg::MSG_HWM_BIT] = msg_evt.above_high_watermark & ~hwm_d_r;
		msg_set[rlsb_pkg::MSG_NOT_EMPTY_BIT] = msg_evt.buffer_not_empty & ~ne_d_r;
	end

	// latched, cleared by a read, a new event wins over the clear
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			msg_r <= rlsb_pkg::RST_BYTE;
		end else begin
			msg_r <= (msg_r & {8{~rd_msg}}) | msg_set;
		end
	end

	// ---------------------------------------------------------------
	// line-link status, bit meaning depends on line mode
	logic spare_sample_d_r;
	logic [rlsb_pkg::SPARE_BITS-1:0] spare_prev_r;
	logic spare_change;
	logic [7:0] link_set, link_r;


	// previous spare bits, compared only at each new sample; the primed
	// flag stops a false change against the reset value
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			spare_prev_r <= '0;
			spare_sample_d_r <= 1'b0;
		end else begin
			spare_sample_d_r <= spare_sample_d_r | link_evt.spare_sample;
			if (link_evt.spare_sample) begin
				spare_prev_r <= link_evt.spare_bits;
			end
		end
	end

	// first sample only primes the history
	assign spare_change = link_evt.spare_sample && spare_sample_d_r
		&& (|((link_evt.spare_bits ^ spare_prev_r) & spare_bit_select_mask));


	// event sources of the link status byte; sources of the other line
	// mode are held off, but bits latched before a mode switch stay until read
	always_comb begin
		link_set = '0;
		if (mode_e1) begin
			link_set[rlsb_pkg::LNK_SPARE6_BIT] = link_evt.spare6_codeword_detect;
			link_set[rlsb_pkg::LNK_SPARE_CHG_BIT] = spare_change;
		end else begin
			link_set[rlsb_pkg::LNK_RAI_CI_BIT] = link_evt.remote_alarm_ci_pattern
				& esf_mode & link_evt.remote_alarm_present;
			link_set[rlsb_pkg::LNK_AIS_CI_BIT] = link_evt.alarm_indication_ci_pattern
				& link_evt.alarm_indication_present;
			link_set[rlsb_pkg::LNK_SLC_ALIGN_BIT] = link_evt.subscriber_carrier_alignment
				& link_evt.slc_data_ready;
			link_set[rlsb_pkg::LNK_DL_FULL_BIT] = link_evt.data_link_full_event;
			link_set[rlsb_pkg::LNK_BOC_CLEAR_BIT] = link_evt.bit_message_clear;
			link_set[rlsb_pkg::LNK_BOC_DETECT_BIT] = link_evt.bit_message_detect;
		end
	end

	// latched, cleared by a read, a new event wins over the clear
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			link_r <= rlsb_pkg::RST_BYTE;
		end else begin
			link_r <= (link_r & {8{~rd_link}}) | link_set;
		end
	end

	// ---------------------------------------------------------------
	// signalling change banks; in 2.048 CAS the LSB of bank 0 and bank 2
	// carry the alignment slot and the reserved/alarm slot as fed in
	logic [rlsb_pkg::CHANNELS-1:0] sig_set;
	logic [7:0] sig_r [rlsb_pkg::SIG_BANKS];

	genvar gb;
	generate
		for (gb = 0; gb < rlsb_pkg::SIG_BANKS; gb++) begin : g_sig
			logic bank_on;
			assign bank_on = (gb != rlsb_pkg::SIG_BANK_E1_ONLY) || mode_e1;
			assign sig_set[gb*8 +: 8] = sig_state_change[gb*8 +: 8] & {8{bank_on}};

			// held until its bank is read
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					sig_r[gb] <= rlsb_pkg::RST_BYTE;
				end else begin
					sig_r[gb] <= (sig_r[gb] & {8{~rd_sig[gb]}})
						| sig_set[gb*8 +: 8];
				end
			end
		end
	endgenerate


	// summary event for enabled channels and its masked interrupt request;
	// the interrupt pulse is a request, its latch lives outside
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			signalling_change_summary <= 1'b0;
			interrupt_out_n <= 1'b1;
		end else begin
			signalling_change_summary <= |(sig_set & signalling_change_enable);
			interrupt_out_n <= ~((|(sig_set & signalling_change_enable))
				& event_interrupt_mask);
		end
	end

	// ---------------------------------------------------------------
	// spare-code definition, high byte
	logic [7:0] code_r;


	// host write stores the pattern and restarts integration; any write,
	// even of the same value, restarts it
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			code_r <= rlsb_pkg::RST_BYTE;
			spare_code_restart <= 1'b0;
		end else begin
			spare_code_restart <= wr_code;
			if (wr_code) begin
				code_r <= host_req.wdata;
			end
		end
	end

	// care mask: bit 7 is the first pattern bit, bit i counts at length > 7-i
	logic [7:0] care_nxt;
	genvar gc;
	generate
		for (gc = 0; gc < rlsb_pkg::CODE_BYTE_BITS; gc++) begin : g_care
			assign care_nxt[gc] = (spare_code_length >
				4'(rlsb_pkg::CODE_BYTE_BITS - 1 - gc));
		end
	endgenerate


	// registered care mask and masked pattern for the detector; the
	// pattern lags the stored byte by one cycle after a write
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			spare_code_care <= rlsb_pkg::RST_BYTE;
			spare_code_pattern <= rlsb_pkg::RST_BYTE;
		end else begin
			spare_code_care <= care_nxt;
			spare_code_pattern <= code_r & care_nxt;
		end
	end

	// ---------------------------------------------------------------
	// read data, one cycle after the read strobe; unmapped reads zero
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			host_rdata <= rlsb_pkg::RST_BYTE;
		end else if (host_req.rd) begin
			case (host_req.addr)
				rlsb_pkg::OFF_MSG_STATUS: begin
					host_rdata <= msg_r;
				end
				rlsb_pkg::OFF_LINK_STATUS: begin
					host_rdata <= link_r;
				end
				rlsb_pkg::OFF_SIG_CHG_1_8: begin
					host_rdata <= sig_r[0];
				end
				rlsb_pkg::OFF_SIG_CHG_9_16: begin
					host_rdata <= sig_r[1];
				end
				rlsb_pkg::OFF_SIG_CHG_17_24: begin
					host_rdata <= sig_r[2];
				end
				rlsb_pkg::OFF_SIG_CHG_25_32: begin
					host_rdata <= sig_r[3];
				end
				rlsb_pkg::OFF_SPARE_CODE_HI: begin
					host_rdata <= code_r;
				end
				default: begin
					host_rdata <= rlsb_pkg::RST_BYTE; // unmapped reads zero
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// File: test/rlsb_host_model.sv
/* rlsb_host_model: host software side of the register port.
   Assumes callers start each access just after a rising sys_clk edge. */
`timescale 1ns/100ps
`default_nettype none
module rlsb_host_model (
	input wire logic sys_clk,
	output var rlsb_pkg::rlsb_host_req_s host_req
);
	// idle port at time zero
	initial host_req = '0;
	// strobe held to the taking edge, then released with scrambled lines
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
		host_req <= '{wr: wr, rd: !wr, addr: addr, wdata: wd};
		@(posedge sys_clk);
		host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wd};
		@(posedge sys_clk);
		repeat ($urandom_range(1, 0)) @(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

// File: test/rlsb_status_bank_monitor.sv
/* rlsb_status_bank_monitor: port timing checks for the status bank.
   Assumes it is bound into rlsb_status_bank, one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module rlsb_status_bank_monitor (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire rlsb_pkg::rlsb_host_req_s host_req,
	input wire logic mode_e1,
	input wire logic cas_enable,
	input wire logic superframe_boundary,
	input wire logic cas_mf_boundary,
	input wire logic [31:0] sig_state_change,
	input wire logic [31:0] signalling_change_enable,
	input wire logic event_interrupt_mask,
	input wire logic [3:0] spare_code_length,
	input wire logic multiframe_event,
	input wire logic signalling_change_summary,
	input wire logic interrupt_out_n,
	input wire logic [7:0] spare_code_care,
	input wire logic [7:0] spare_code_pattern,
	input wire logic spare_code_restart
);
	logic [7:0] care_exp;
	logic code_wr;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// care mask expected for the selected length, top bit first
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			care_exp[i] = spare_code_length > 4'(7 - i);
		end
	end
	// host write to the spare-code register
	assign code_wr = host_req.wr && host_req.addr == rlsb_pkg::OFF_SPARE_CODE_HI;
	irq_follows_sum_a: assert property (
		interrupt_out_n == !(signalling_change_summary && $past(event_interrupt_mask)))
		else $error("interrupt pulse not tied to masked summary");
	sum_needs_enable_a: assert property (signalling_change_summary |->
		$past(|(sig_state_change & signalling_change_enable))) else $error("summary without cause");
	sum_fires_a: assert property (
		|(sig_state_change[23:0] & signalling_change_enable[23:0]) |=> signalling_change_summary)
		else $error("enabled change gave no summary");
	mf_superframe_a: assert property (!mode_e1 && superframe_boundary |=> multiframe_event)
		else $error("superframe boundary gave no multiframe event");
	mf_t1_source_a: assert property (multiframe_event && $past(!mode_e1) |->
		$past(superframe_boundary)) else $error("stray multiframe event");
	mf_cas_a: assert property (mode_e1 && cas_enable && cas_mf_boundary |=> multiframe_event)
		else $error("cas boundary gave no multiframe event");
	restart_after_wr_a: assert property (code_wr |=> spare_code_restart)
		else $error("code write gave no restart");
	restart_cause_a: assert property (spare_code_restart |-> $past(code_wr))
		else $error("restart without code write");
	care_mask_a: assert property (
		!$past(sys_rst) |-> spare_code_care == $past(care_exp))
		else $error("care mask wrong for length");
	pattern_masked_a: assert property ((spare_code_pattern & ~spare_code_care) == 8'h00)
		else $error("pattern has bits beyond length");
endmodule
bind rlsb_status_bank rlsb_status_bank_monitor mon_u (.sys_clk, .sys_rst, .host_req, .mode_e1,
	.cas_enable, .superframe_boundary, .cas_mf_boundary, .sig_state_change,
	.signalling_change_enable, .event_interrupt_mask, .spare_code_length, .multiframe_event,
	.signalling_change_summary, .interrupt_out_n, .spare_code_care, .spare_code_pattern,
	.spare_code_restart);
`default_nettype wire

// File: test/rlsb_status_bank_tb_top.sv
/* rlsb_status_bank_tb_top: self-checking bench for the status bank.
   Assumes the host model owns the register port; the bench drives events. */
`timescale 1ns/100ps
`default_nettype none
module rlsb_status_bank_tb_top;
	localparam int MF = 20;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic mode_e1 = 1'b0;
	logic esf_mode = 1'b1;
	logic cas_enable = 1'b0;
	logic superframe_boundary = 1'b0;
	logic cas_mf_boundary = 1'b0;
	logic event_interrupt_mask = 1'b1;
	logic [3:0] spare_code_length = 4'h8;
	logic [4:0] spare_bit_select_mask = 5'h03;
	logic [31:0] sig_state_change = '0;
	logic [31:0] signalling_change_enable = '0;
	rlsb_pkg::rlsb_msg_evt_s msg_evt = '0;
	rlsb_pkg::rlsb_link_evt_s link_evt = '0;
	rlsb_pkg::rlsb_host_req_s host_req;
	logic [7:0] host_rdata, spare_code_care, spare_code_pattern, v;
	logic multiframe_event, signalling_change_summary, interrupt_out_n, spare_code_restart;
	logic rd_d = 1'b0;
	logic en;
	logic [3:0] ln;
	logic [7:0] exp_q[$];
	int err_total = 0;
	int checks = 0;
	int n_rst = 0;
	int ch, n;
	logic [15:0] lk_v[14] = '{16'h8000, 16'hc000, 16'h2000, 16'h3000, 16'h0800, 16'h0c00,
		16'h0200, 16'h0080, 16'h0100, 16'h0200, 16'h0040, 16'h0020, 16'h0030, 16'h0031};
	logic [7:0] lk_e[14] = '{8'h00, 8'h20, 8'h00, 8'h10, 8'h00, 8'h08, 8'h04, 8'h02, 8'h01,
		8'h00, 8'h02, 8'h00, 8'h00, 8'h01};
	logic [7:0] mg_e[8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h08, 8'h08, 8'h10, 8'h28};
	logic [7:0] regs[8] = '{8'h94, 8'h95, 8'h96, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c};
	rlsb_status_bank #(.MF_CYCLES(MF)) dut_u (.sys_clk, .sys_rst, .host_req, .host_rdata,
		.mode_e1, .esf_mode, .cas_enable, .superframe_boundary, .cas_mf_boundary, .msg_evt,
		.link_evt, .spare_bit_select_mask, .sig_state_change, .signalling_change_enable,
		.event_interrupt_mask, .spare_code_length, .multiframe_event,
		.signalling_change_summary, .interrupt_out_n, .spare_code_care, .spare_code_pattern,
		.spare_code_restart);
	rlsb_host_model host_u (.sys_clk, .host_req);
	// bench clock
	initial forever #25 sys_clk = ~sys_clk;
	// read data is loaded at the taking edge and checked one edge later; restarts are counted
	always @(posedge sys_clk) begin
		rd_d <= host_req.rd;
		if (rd_d === 1'b1)
			cmp(host_rdata, exp_q.pop_front());
		if (spare_code_restart === 1'b1)
			n_rst++;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host_u.access(1'b0, a, 8'h00);
	endtask
	// one event cycle, then a read of the register it lands in
	task automatic ev(input logic [7:0] m, input logic [15:0] l, input logic [7:0] a,
		input logic [7:0] e);
		msg_evt <= m;
		link_evt <= l;
		tick(1);
		msg_evt <= '0;
		link_evt <= '0;
		tick(1);
		rd(a, e);
	endtask
	// boundary pulse in the given mode, event looked at mid-cycle
	task automatic pulse_mf(input logic e1);
		mode_e1 <= e1;
		cas_enable <= e1;
		superframe_boundary <= !e1;
		cas_mf_boundary <= e1;
		tick(1);
		superframe_boundary <= 1'b0;
		cas_mf_boundary <= 1'b0;
		@(negedge sys_clk);
		cmp(8'(multiframe_event), 8'h01);
		@(posedge sys_clk);
	endtask
	function automatic logic [7:0] care_of(input logic [3:0] len);
		for (int i = 0; i < 8; i++)
			care_of[i] = len > 4'(7 - i);
	endfunction
	task automatic report_and_stop();
		$display("mismatches %0d, comparisons %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		void'($urandom(14910));
		tick(2);
		sys_rst <= 1'b0;
		tick(1);
		foreach (regs[i])
			rd(regs[i], 8'h00);
		for (int i = 0; i < 8; i++) begin
			ev(8'(1 << i), 16'h0000, 8'h94, mg_e[i]);
			rd(8'h94, 8'h00);
		end
		msg_evt <= 8'h04;
		fork
			rd(8'h94, 8'h00);
			begin
				tick(1);
				msg_evt <= '0;
			end
		join
		rd(8'h94, 8'h04);
		for (int i = 0; i < 14; i++) begin
			mode_e1 <= (i > 8);
			ev(8'h00, lk_v[i], 8'h96, lk_e[i]);
		end
		repeat (4) begin
			ch = $urandom_range(31, 0);
			signalling_change_enable <= $urandom;
			event_interrupt_mask <= 1'($urandom_range(1, 0));
			sig_state_change <= 32'h0000_0001 << ch;
			tick(1);
			sig_state_change <= '0;
			@(negedge sys_clk);
			en = signalling_change_enable[ch];
			cmp(8'(signalling_change_summary), 8'(en));
			cmp(8'(interrupt_out_n), 8'(!(en && event_interrupt_mask)));
			tick(1);
			for (int b = 0; b < 4; b++)
				rd(8'h98 + 8'(b), 8'((32'h0000_0001 << ch) >> (8 * b)));
			for (int b = 0; b < 4; b++)
				rd(8'h98 + 8'(b), 8'h00);
		end
		mode_e1 <= 1'b0;
		ev(8'h00, 16'h0000, 8'h9b, 8'h00);
		sig_state_change <= 32'h0800_0000;
		tick(1);
		sig_state_change <= '0;
		tick(1);
		rd(8'h9b, 8'h00);
		esf_mode <= 1'b0;
		ev(8'h00, 16'hc000, 8'h96, 8'h00);
		esf_mode <= 1'b1;
		pulse_mf(1'b0);
		pulse_mf(1'b1);
		cas_enable <= 1'b0;
		for (int p = 0; p < 2; p++) begin
			n = 0;
			do begin
				@(negedge sys_clk);
				n++;
			end while (multiframe_event !== 1'b1 && n < 100);
		end
		cmp(8'(n), 8'(MF));
		@(posedge sys_clk);
		for (int w = 0; w < 3; w++) begin
			v = 8'($urandom);
			ln = (w == 0) ? 4'h1 : 4'($urandom_range(8, 1));
			spare_code_length <= ln;
			host_u.access(1'b1, 8'h9c, v);
			@(negedge sys_clk);
			cmp(spare_code_care, care_of(ln));
			cmp(spare_code_pattern, v & care_of(ln));
			@(posedge sys_clk);
			rd(8'h9c, v);
		end
		tick(3);
		cmp(8'(n_rst), 8'h03);
		report_and_stop();
	end
	// hang guard, far beyond the expected run length
	initial begin
		#2000000;
		err_total++;
		report_and_stop();
	end
endmodule
`default_nettype wire
